//--- pkg/floppy_read_map.svh
// offsets, field positions and timing counts
// assumes a 50 MHz core clock
`ifndef FLOPPY_READ_MAP_SVH
`define FLOPPY_READ_MAP_SVH
// opcodes in the low five bits of the first byte
`define OP_READ_DATA 5'h06
`define OP_READ_DELETED 5'h0C
`define OP_SENSE_DRIVE 5'h04
// flag positions in the first byte; head select sits in the select byte
`define BIT_MULTI_TRACK 7
`define BIT_DOUBLE_DENSITY 6
`define BIT_DELETED_BYPASS 5
`define BIT_HEAD_SELECT 2
// command lengths and parameter slots
`define CMD_LEN_READ 4'h9
`define CMD_LEN_SENSE 4'h2
`define RES_LEN_READ 3'h7
`define IDX_SELECT 4'h1
`define IDX_CYL 4'h2
`define IDX_HEAD 4'h3
`define IDX_SECTOR 4'h4
`define IDX_SIZE 4'h5
`define IDX_FINAL 4'h6
// status fields
`define STATUS_TWO_CONTROL_MARK 6
`define STATUS_THREE_TRACK_ZERO 4
// timing
`define CLK_MHZ 50
`define STEP_UNIT_US 500
`define STEP_UNIT_CYCLES (`STEP_UNIT_US * `CLK_MHZ)
`define STEP_UNITS_FULL 5'h10
`define POLL_PERIOD_US 1000
`define POLL_CYCLES (`POLL_PERIOD_US * `CLK_MHZ)
`define WG_DELAY_US 2
`define WG_DELAY_CYCLES (`WG_DELAY_US * `CLK_MHZ)
`endif

//--- pkg/floppy_read_pkg.sv
// types shared by the read-command block and its helpers
// assumes floppy_read_map.svh for all numbers
package floppy_read_pkg;
  // command phases
  typedef enum logic [1:0] {PH_IDLE, PH_CMD, PH_EXEC, PH_RESULT} phase_t;
  // one byte as the drive side presents it
  typedef struct packed {
    logic deleted; // sector carries a deleted data mark
    logic last; // last byte of the sector
    logic [7:0] data;
  } drive_byte_t;
endpackage

//--- rtl/two_entry_buffer.sv
// two-entry valid/ready buffer in the read data path
// assumes one clock; output word comes straight from a flop
`timescale 1ns/1ps
module two_entry_buffer #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // filling side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // draining side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  initial begin
    if (WIDTH < 1) $error("width must be positive");
  end
  logic [WIDTH-1:0] head_q, head_d, tail_q, tail_d; // head is the oldest word
  logic [1:0] cnt_q, cnt_d;
  logic push, pop;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign in_ready = (cnt_q != 2'h2); // full stalls the source
  assign out_valid = (cnt_q != 2'h0);
  assign out_data = head_q;
  // next contents
  always_comb begin
    head_d = head_q;
    tail_d = tail_q;
    cnt_d = cnt_q;
    if (push && pop) begin
      if (cnt_q == 2'h1) head_d = in_data;
      else begin
        head_d = tail_q;
        tail_d = in_data;
      end
    end else if (push) begin
      if (cnt_q == 2'h0) head_d = in_data;
      else tail_d = in_data;
      cnt_d = cnt_q + 2'h1;
    end else if (pop) begin
      head_d = tail_q;
      cnt_d = cnt_q - 2'h1;
    end
  end
  // registers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      head_q <= '0;
      tail_q <= '0;
      cnt_q <= 2'h0;
    end else begin
      head_q <= head_d;
      tail_q <= tail_d;
      cnt_q <= cnt_d;
    end
  end
endmodule // two_entry_buffer

//--- rtl/step_timer.sv
// step interval timer: fires once after (16 - code) half-millisecond units
// assumes start is a one-cycle pulse from the same clock
`timescale 1ns/1ps
`include "floppy_read_map.svh"
module step_timer #(
  parameter int UNIT_CYCLES = `STEP_UNIT_CYCLES
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // control
  input wire logic start,
  input wire logic [3:0] code,
  output logic fire
);
  initial begin
    if (UNIT_CYCLES < 1) $error("unit must be at least one cycle");
  end
  logic [31:0] div_q, div_d; // half-millisecond divider
  logic [4:0] units_q, units_d;
  logic run_q, run_d;
  logic unit_en;
  assign unit_en = run_q && (div_q == 32'(UNIT_CYCLES - 1));
  // fire straight from the counters: the caller can restart on the expiry cycle,
  // so back-to-back intervals carry no extra register cycles
  assign fire = unit_en && (units_q == 5'h1);
  // next state: code 0 is the longest interval, 15 the shortest
  always_comb begin
    div_d = div_q;
    units_d = units_q;
    run_d = run_q;
    if (start) begin
      run_d = 1'b1;
      div_d = 32'h0;
      units_d = `STEP_UNITS_FULL - {1'b0, code};
    end else if (run_q) begin
      div_d = unit_en ? 32'h0 : div_q + 32'h1;
      if (unit_en) begin
        units_d = units_q - 5'h1;
        if (units_q == 5'h1) begin
          run_d = 1'b0;
        end
      end
    end
  end
  // registers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      div_q <= 32'h0;
      units_q <= 5'h0;
      run_q <= 1'b0;
    end else begin
      div_q <= div_d;
      units_q <= units_d;
      run_q <= run_d;
    end
  end
endmodule // step_timer

//--- rtl/floppy_read_cmd.sv
// read data command interpreter: command, execution and result phases
// assumes host strobes on core_clk; drive pins are asynchronous
// How it works
// - nine command bytes: flags, select, then parameters
// - last command byte starts sector data execution
// - result begins with status zero, one, two
// - then cylinder, head, sector, size: seven reads
// - present cylinder latched when sense interrupt completes
// - polling disable bit stops the polling tick
// - eight-bit precompensation start track, any value
// - transfer starts at given sector, then increments
// - relative seek offsets the current head position
// - skip on read drops deleted-mark sectors
// - skip on read deleted takes only deleted
// - skip clear reads every sector unchanged
// - step interval 0.5 to 8 ms steps
// - four status registers, read only in result
// - write gate timing shifts write enable
// - non-dma interrupts per byte, else dma request
`timescale 1ns/1ps
`include "floppy_read_map.svh"
module floppy_read_cmd #(
  parameter int STEP_UNIT = `STEP_UNIT_CYCLES,
  parameter int POLL_PERIOD = `POLL_CYCLES
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // host command and result bytes
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_data,
  output logic cmd_ready,
  input wire logic res_rd,
  output logic [7:0] res_data,
  output logic res_valid,
  // sector data toward the system
  output logic [7:0] data_out,
  output logic dma_req,
  output logic host_irq,
  input wire logic data_ack,
  // drive read pins
  input wire logic drv_strobe,
  input wire logic [7:0] drv_data,
  input wire logic drv_deleted,
  input wire logic drv_last,
  output logic drv_hold,
  // configuration
  input wire logic non_dma_flag,
  input wire logic poll_disable,
  input wire logic [7:0] precomp_start_track,
  input wire logic [7:0] sectors_per_track,
  input wire logic count_mode,
  input wire logic [3:0] step_interval,
  input wire logic write_gate_timing,
  // seek and drive control
  input wire logic seek_go,
  input wire logic [7:0] relative_cylinder,
  input wire logic seek_outward,
  input wire logic sense_int_done,
  input wire logic wr_req,
  output logic [7:0] present_cylinder,
  output logic step,
  output logic step_dir,
  output logic precomp_on,
  output logic poll_tick,
  output logic wr_enable
);
  initial begin
    if (POLL_PERIOD < 1) $error("poll period must be at least one cycle");
  end
  // ----------------------------------------
  // drive pin synchronisers
  // ----------------------------------------
  floppy_read_pkg::drive_byte_t sync1_q, sync2_q; // sync1 feeds only sync2
  logic [1:0] strobe_sync_q;
  logic strobe_old_q;
  logic drv_take;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sync1_q <= '0;
      sync2_q <= '0;
      strobe_sync_q <= 2'h0;
      strobe_old_q <= 1'b0;
    end else begin
      sync1_q <= '{deleted: drv_deleted, last: drv_last, data: drv_data};
      sync2_q <= sync1_q;
      strobe_sync_q <= {strobe_sync_q[0], drv_strobe};
      strobe_old_q <= strobe_sync_q[1];
    end
  end
  // rising edge of the strobe marks a new byte; data settled two cycles earlier
  assign drv_take = strobe_sync_q[1] && !strobe_old_q;
  // ----------------------------------------
  // command / result sequencer
  // ----------------------------------------
  floppy_read_pkg::phase_t phase_q, phase_d;
  logic [7:0] params_q [0:8]; // command bytes by position
  logic [3:0] idx_q, idx_d, len_q, len_d;
  logic [7:0] sector_q, sector_d, done_cnt_q, done_cnt_d;
  logic [7:0] status_zero_q, status_zero_d, status_one_q;
  logic [7:0] status_two_q, status_two_d, status_three_q, status_three_d;
  logic [7:0] res_data_d;
  logic res_valid_d, cmd_ready_d, mark_seen_q, mark_seen_d;
  logic cmd_take, res_take, skip_sector, read_del, buf_in_ready, buf_push;
  logic [7:0] head_pos_q, head_pos_d;
  assign cmd_take = cmd_valid && cmd_ready;
  assign res_take = res_rd && res_valid;
  assign read_del = (params_q[0][4:0] == `OP_READ_DELETED);
  // skip decision per sector: mode decides which mark is dropped
  always_comb begin
    skip_sector = 1'b0;
    if (params_q[0][`BIT_DELETED_BYPASS]) begin
      if (read_del) skip_sector = !sync2_q.deleted;
      else skip_sector = sync2_q.deleted;
    end
  end
  assign buf_push = (phase_q == floppy_read_pkg::PH_EXEC) && drv_take && !skip_sector;
  // result byte by position; status three answers the drive-status query
  function automatic logic [7:0] result_byte(input logic [3:0] i, input logic [7:0] s0,
                                             input logic [7:0] s2, input logic sense);
    if (sense) result_byte = status_three_q;
    else if (i == 4'h0) result_byte = s0;
    else if (i == 4'h1) result_byte = status_one_q;
    else if (i == 4'h2) result_byte = s2;
    else if (i == 4'h3) result_byte = params_q[`IDX_CYL];
    else if (i == 4'h4) result_byte = params_q[`IDX_HEAD];
    else if (i == 4'h5) result_byte = sector_q;
    else result_byte = params_q[`IDX_SIZE];
  endfunction
  // next phase, counters and status
  always_comb begin
    phase_d = phase_q;
    idx_d = idx_q;
    len_d = len_q;
    sector_d = sector_q;
    done_cnt_d = done_cnt_q;
    status_zero_d = status_zero_q;
    status_two_d = status_two_q;
    status_three_d = status_three_q;
    mark_seen_d = mark_seen_q;
    res_valid_d = res_valid;
    res_data_d = res_data;
    case (phase_q)
      floppy_read_pkg::PH_IDLE: begin
        if (cmd_take) begin
          idx_d = 4'h1;
          if (cmd_data[4:0] == `OP_READ_DATA || cmd_data[4:0] == `OP_READ_DELETED) begin
            len_d = `CMD_LEN_READ;
            phase_d = floppy_read_pkg::PH_CMD;
          end else if (cmd_data[4:0] == `OP_SENSE_DRIVE) begin
            len_d = `CMD_LEN_SENSE;
            phase_d = floppy_read_pkg::PH_CMD;
          end
        end
      end
      floppy_read_pkg::PH_CMD: begin
        if (cmd_take) begin
          idx_d = idx_q + 4'h1;
          if (idx_q == len_q - 4'h1) begin
            idx_d = 4'h0;
            if (len_q == `CMD_LEN_SENSE) begin
              status_three_d = {3'h0, head_pos_q == 8'h0, 1'b0, cmd_data[2:0]};
              res_data_d = {3'h0, head_pos_q == 8'h0, 1'b0, cmd_data[2:0]};
              res_valid_d = 1'b1;
              phase_d = floppy_read_pkg::PH_RESULT;
            end else begin
              sector_d = params_q[`IDX_SECTOR];
              done_cnt_d = 8'h0;
              mark_seen_d = 1'b0;
              phase_d = floppy_read_pkg::PH_EXEC;
            end
          end
        end
      end
      floppy_read_pkg::PH_EXEC: begin
        if (drv_take && sync2_q.deleted && !skip_sector) mark_seen_d = 1'b1;
        if (drv_take && sync2_q.last && (buf_push || skip_sector)) begin
          sector_d = sector_q + 8'h1;
          done_cnt_d = done_cnt_q + 8'h1;
          // count mode ends on sectors per track, else on the final sector
          if (count_mode ? (done_cnt_q + 8'h1 == sectors_per_track)
                         : (sector_q == params_q[`IDX_FINAL])) begin
            status_zero_d = {5'h0, params_q[`IDX_SELECT][2:0]};
            status_two_d = {1'b0, mark_seen_d != read_del, 6'h0};
            res_data_d = result_byte(4'h0, {5'h0, params_q[`IDX_SELECT][2:0]},
                                     {1'b0, mark_seen_d != read_del, 6'h0}, 1'b0);
            res_valid_d = 1'b1;
            phase_d = floppy_read_pkg::PH_RESULT;
          end
        end
      end
      floppy_read_pkg::PH_RESULT: begin
        if (res_take) begin
          idx_d = idx_q + 4'h1;
          res_data_d = result_byte(idx_q + 4'h1, status_zero_q, status_two_q, 1'b0);
          if (len_q == `CMD_LEN_SENSE || idx_q == 4'(`RES_LEN_READ - 3'h1)) begin
            idx_d = 4'h0;
            res_valid_d = 1'b0;
            res_data_d = 8'h0;
            phase_d = floppy_read_pkg::PH_IDLE;
          end
        end
      end
      default: phase_d = floppy_read_pkg::PH_IDLE;
    endcase
    // command bytes only in idle or command phase
    cmd_ready_d = (phase_d == floppy_read_pkg::PH_IDLE) || (phase_d == floppy_read_pkg::PH_CMD);
  end
  // sequencer registers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      phase_q <= floppy_read_pkg::PH_IDLE;
      for (int i = 0; i < 9; i++) params_q[i] <= 8'h0;
      idx_q <= 4'h0;
      len_q <= 4'h0;
      sector_q <= 8'h0;
      done_cnt_q <= 8'h0;
      status_zero_q <= 8'h0;
      status_one_q <= 8'h0;
      status_two_q <= 8'h0;
      status_three_q <= 8'h0;
      mark_seen_q <= 1'b0;
      res_data <= 8'h0;
      res_valid <= 1'b0;
      cmd_ready <= 1'b1;
    end else begin
      if (cmd_take) params_q[(phase_q == floppy_read_pkg::PH_IDLE) ? 4'h0 : idx_q] <= cmd_data;
      phase_q <= phase_d;
      idx_q <= idx_d;
      len_q <= len_d;
      sector_q <= sector_d;
      done_cnt_q <= done_cnt_d;
      status_zero_q <= status_zero_d;
      status_one_q <= 8'h0; // no end-of-cylinder or crc faults are modelled
      status_two_q <= status_two_d;
      status_three_q <= status_three_d;
      mark_seen_q <= mark_seen_d;
      res_data <= res_data_d;
      res_valid <= res_valid_d;
      cmd_ready <= cmd_ready_d;
    end
  end
  // ----------------------------------------
  // data path toward the system
  // ----------------------------------------
  logic buf_out_valid, pop_ok;
  logic [7:0] buf_out_data;
  assign pop_ok = data_ack && (dma_req || host_irq);
  two_entry_buffer #(.WIDTH(8)) i_two_entry_buffer (
    .core_clk(core_clk),
    .rst(rst),
    .in_valid(buf_push),
    .in_data(sync2_q.data),
    .in_ready(buf_in_ready),
    .out_valid(buf_out_valid),
    .out_data(buf_out_data),
    .out_ready(pop_ok)
  );
  // request lines follow buffer occupancy; mode picks irq or dma
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dma_req <= 1'b0;
      host_irq <= 1'b0;
      drv_hold <= 1'b0;
      data_out <= 8'h0;
    end else begin
      host_irq <= buf_out_valid && !pop_ok && non_dma_flag;
      dma_req <= buf_out_valid && !pop_ok && !non_dma_flag;
      drv_hold <= !buf_in_ready; // back-pressure toward the drive
      data_out <= buf_out_data;
    end
  end
  // ----------------------------------------
  // head position, stepping, polling, write gate
  // ----------------------------------------
  logic [7:0] target_q, target_d, cyl_report_d;
  logic step_fire, step_start, dir_d, step_d, precomp_d, poll_d, wr_en_d;
  logic [31:0] poll_cnt_q, poll_cnt_d, wg_cnt_q, wg_cnt_d;
  // restart on the expiry cycle itself so successive steps keep the exact interval
  assign step_start = seek_go || (step_fire && head_pos_d != target_q);
  step_timer #(.UNIT_CYCLES(STEP_UNIT)) i_step_timer (
    .core_clk(core_clk),
    .rst(rst),
    .start(step_start),
    .code(step_interval),
    .fire(step_fire)
  );
  // next head state
  always_comb begin
    target_d = target_q;
    head_pos_d = head_pos_q;
    dir_d = step_dir;
    step_d = 1'b0;
    cyl_report_d = present_cylinder;
    if (seek_go) begin
      target_d = seek_outward ? head_pos_q - relative_cylinder
                              : head_pos_q + relative_cylinder;
      dir_d = !seek_outward;
    end else if (step_fire && head_pos_q != target_q) begin
      step_d = 1'b1;
      head_pos_d = step_dir ? head_pos_q + 8'h1 : head_pos_q - 8'h1;
    end
    if (sense_int_done) cyl_report_d = head_pos_q;
    precomp_d = (head_pos_q >= precomp_start_track);
    poll_cnt_d = (poll_cnt_q == 32'(POLL_PERIOD - 1)) ? 32'h0 : poll_cnt_q + 32'h1;
    poll_d = !poll_disable && (poll_cnt_q == 32'(POLL_PERIOD - 1));
    // wait before enabling unless pre-erase timing is selected
    wg_cnt_d = wr_req ? ((wg_cnt_q == 32'(`WG_DELAY_CYCLES)) ? wg_cnt_q : wg_cnt_q + 32'h1)
                      : 32'h0;
    wr_en_d = wr_req && (write_gate_timing || wg_cnt_q == 32'(`WG_DELAY_CYCLES));
  end
  // head registers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      target_q <= 8'h0;
      head_pos_q <= 8'h0;
      step_dir <= 1'b0;
      step <= 1'b0;
      present_cylinder <= 8'h0;
      precomp_on <= 1'b0;
      poll_cnt_q <= 32'h0;
      poll_tick <= 1'b0;
      wg_cnt_q <= 32'h0;
      wr_enable <= 1'b0;
    end else begin
      target_q <= target_d;
      head_pos_q <= head_pos_d;
      step_dir <= dir_d;
      step <= step_d;
      present_cylinder <= cyl_report_d;
      precomp_on <= precomp_d;
      poll_cnt_q <= poll_cnt_d;
      poll_tick <= poll_d;
      wg_cnt_q <= wg_cnt_d;
      wr_enable <= wr_en_d;
    end
  end
  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_last_cmd;
    cmd_take && phase_q == floppy_read_pkg::PH_CMD && idx_q == len_q - 4'h1;
  endsequence
  sequence s_last_res;
    res_take && idx_q == 4'h6 && len_q == `CMD_LEN_READ;
  endsequence
  chk_exec_count: assert property (@(posedge core_clk) disable iff (rst)
    $rose(phase_q == floppy_read_pkg::PH_EXEC) |-> $past(idx_q) == 4'h8)
    else $error("execution entered without nine command bytes");
  chk_exec_entry: assert property (@(posedge core_clk) disable iff (rst)
    s_last_cmd and len_q == `CMD_LEN_READ |=> phase_q == floppy_read_pkg::PH_EXEC)
    else $error("last command byte did not start execution");
  chk_result_first: assert property (@(posedge core_clk) disable iff (rst)
    $rose(res_valid) && len_q == `CMD_LEN_READ |-> idx_q == 4'h0 && res_data == status_zero_q)
    else $error("result did not open with status zero");
  chk_result_end: assert property (@(posedge core_clk) disable iff (rst)
    s_last_res |=> phase_q == floppy_read_pkg::PH_IDLE && !res_valid ##1 cmd_ready)
    else $error("no return to idle after seventh result byte");
  chk_result_gate: assert property (@(posedge core_clk) disable iff (rst)
    res_valid |-> phase_q == floppy_read_pkg::PH_RESULT)
    else $error("result byte offered outside result phase");
  chk_cyl_latch: assert property (@(posedge core_clk) disable iff (rst)
    sense_int_done |=> present_cylinder == $past(head_pos_q))
    else $error("present cylinder not taken at sense completion");
  chk_poll_off: assert property (@(posedge core_clk) disable iff (rst)
    poll_disable |=> !poll_tick)
    else $error("polling tick while disabled");
  chk_skip_drop: assert property (@(posedge core_clk) disable iff (rst)
    buf_push && params_q[0][`BIT_DELETED_BYPASS] && !read_del |-> !sync2_q.deleted)
    else $error("deleted sector passed with skip set");
  chk_step_pulse: assert property (@(posedge core_clk) disable iff (rst)
    step |=> !step [*2])
    else $error("step pulses closer than the interval");
endmodule // floppy_read_cmd

//--- test/drive_model.sv
// drive model: streams sectors of bytes on the read pins
// assumes core_clk is shared with the block and drv_hold comes from it
`timescale 1ns/1ps
module drive_model #(
  parameter int BYTES = 3
) (
  // clock and flow control
  input wire logic core_clk,
  input wire logic drv_hold,
  // start request from the bench
  input wire logic go,
  input wire logic [3:0] nsec,
  input wire logic [7:0] del_mask,
  // read pins
  output logic drv_strobe,
  output logic [7:0] drv_data,
  output logic drv_deleted,
  output logic drv_last
);
  // idle pins at time zero
  initial begin
    drv_strobe = 1'b0;
    drv_data = 8'h00;
    drv_deleted = 1'b0;
    drv_last = 1'b0;
  end
  // byte loop: 3 clocks setup, 3 clocks strobe, never strobe while held
  always @(posedge go) begin
    for (int s = 0; s < nsec; s++) begin
      for (int k = 0; k < BYTES; k++) begin
        drv_data = 8'(16 * (s + 1) + k);
        drv_deleted = del_mask[s];
        drv_last = (k == BYTES - 1);
        repeat (3) @(posedge core_clk);
        // look at the hold flag only once it has settled after the edge
        #1;
        while (drv_hold) begin
          @(posedge core_clk);
          #1;
        end
        drv_strobe = 1'b1;
        repeat (3) @(posedge core_clk);
        #1 drv_strobe = 1'b0;
        // released pins show the inverse so stale values never match
        drv_data = ~drv_data;
        drv_deleted = ~drv_deleted;
        drv_last = ~drv_last;
        @(posedge core_clk);
        #1;
      end
    end
  end
endmodule // drive_model

//--- test/tb_floppy_read_cmd.sv
// bench for the read command block: host tasks beside a drive model
// assumes short STEP_UNIT and POLL_PERIOD so the run stays brief
`timescale 1ns/1ps
module tb_floppy_read_cmd;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic core_clk, rst, cmd_valid, cmd_ready, res_rd, res_valid, go;
  logic [7:0] cmd_data, res_data, data_out, drv_data, del_mask;
  logic dma_req, host_irq, data_ack, drv_strobe, drv_deleted, drv_last, drv_hold;
  logic [7:0] precomp_start_track, sectors_per_track, relative_cylinder, present_cylinder;
  logic non_dma_flag, poll_disable, count_mode, write_gate_timing, seek_go, seek_outward;
  logic sense_int_done, wr_req, step, step_dir, precomp_on, poll_tick, wr_enable;
  logic [3:0] step_interval, nsec;
  int fail_count = 0;
  int checks_done = 0;
  int cycles = 0;
  // short counts: one step unit is 4 cycles, poll every 8
  floppy_read_cmd #(.STEP_UNIT(4), .POLL_PERIOD(8)) i_floppy_read_cmd (.*);
  drive_model i_drive_model (.*);
  // 50 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // hang guard
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      conclude();
    end
  end
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic tick(int n = 1);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // valid held until the edge where ready is high
  task automatic send(logic [7:0] q[$]);
    foreach (q[i]) begin
      cmd_valid = 1'b1;
      cmd_data = q[i];
      for (int w = 0; w < 50 && cmd_ready !== 1'b1; w++) tick();
      tick();
    end
    cmd_valid = 1'b0;
  endtask
  task automatic read_cmd(logic [7:0] op, logic [7:0] r, logic [7:0] fin);
    send('{op, 8'h05, 8'h07, 8'h01, r, 8'h02, fin, 8'h1B, 8'hFF});
  endtask
  // compares the first entries, consumes n result bytes
  task automatic result(logic [7:0] q[$], int n);
    for (int i = 0; i < n; i++) begin
      for (int w = 0; w < 200 && res_valid !== 1'b1; w++) tick();
      if (i < q.size()) chk("res_data", q[i], res_data);
      res_rd = 1'b1;
      tick();
      res_rd = 1'b0;
      tick();
    end
  endtask
  task automatic take(logic [7:0] exp, bit irq);
    for (int w = 0; w < 300 && (irq ? host_irq : dma_req) !== 1'b1; w++) tick();
    chk("data_out", exp, data_out);
    data_ack = 1'b1;
    tick();
    data_ack = 1'b0;
    tick();
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_read_plain();
    non_dma_flag = 1'b0;
    count_mode = 1'b0;
    read_cmd(8'h46, 8'h01, 8'h02);
    tick(2);
    chk("res_valid in exec", 8'h00, res_valid);
    nsec = 4'h2;
    del_mask = 8'h02;
    go = 1'b1;
    tick();
    go = 1'b0;
    tick(60);
    chk("drv_hold on stall", 8'h01, drv_hold);
    for (int s = 0; s < 2; s++)
      for (int k = 0; k < 3; k++) take(8'(16 * (s + 1) + k), 1'b0);
    result('{8'h05, 8'h00, 8'h40, 8'h07, 8'h01, 8'h03, 8'h02}, 7);
    tick();
    chk("cmd_ready after result", 8'h01, cmd_ready);
    $display("test read plain done");
  endtask
  // skip flag set, sector count ends execution
  task automatic t_skip(logic [7:0] op, int keep);
    non_dma_flag = 1'b1;
    count_mode = 1'b1;
    sectors_per_track = 8'h02;
    read_cmd(op, 8'h01, 8'h09);
    nsec = 4'h2;
    del_mask = 8'h01;
    go = 1'b1;
    tick();
    go = 1'b0;
    for (int k = 0; k < 3; k++) take(8'(16 * keep + k), 1'b1);
    result('{8'h05, 8'h00, 8'h00}, 7);
    $display("test skip done");
  endtask
  task automatic t_seek();
    int n;
    int first;
    int last;
    n = 0;
    send('{8'h04, 8'h05});
    result('{8'h15}, 1);
    precomp_start_track = 8'h02;
    step_interval = 4'hF;
    relative_cylinder = 8'h03;
    seek_go = 1'b1;
    tick();
    seek_go = 1'b0;
    for (int c = 0; c < 60; c++) begin
      if (step === 1'b1) begin
        if (n == 0) first = c;
        last = c;
        n++;
        chk("step_dir", 8'h01, step_dir);
      end
      tick();
    end
    chk("step count", 8'h03, 8'(n));
    chk("step spacing", 8'h08, 8'(last - first));
    chk("cylinder before sense", 8'h00, present_cylinder);
    sense_int_done = 1'b1;
    tick();
    sense_int_done = 1'b0;
    tick(2);
    chk("present_cylinder", 8'h03, present_cylinder);
    chk("precomp_on", 8'h01, precomp_on);
    seek_outward = 1'b1;
    relative_cylinder = 8'h02;
    seek_go = 1'b1;
    tick();
    seek_go = 1'b0;
    tick(12);
    chk("step_dir outward", 8'h00, step_dir);
    chk("precomp_on below start", 8'h00, precomp_on);
    $display("test seek done");
  endtask
  task automatic t_poll_write_gate_timing();
    int n;
    for (int d = 0; d < 2; d++) begin
      poll_disable = d[0];
      tick(9);
      n = 0;
      for (int c = 0; c < 32; c++) begin
        n += poll_tick;
        tick();
      end
      chk("poll ticks", d ? 8'h00 : 8'h04, 8'(n));
    end
    write_gate_timing = 1'b1;
    wr_req = 1'b1;
    tick(2);
    chk("wr_enable prompt", 8'h01, wr_enable);
    wr_req = 1'b0;
    tick(3);
    write_gate_timing = 1'b0;
    wr_req = 1'b1;
    tick(50);
    chk("wr_enable delayed", 8'h00, wr_enable);
    tick(60);
    chk("wr_enable late", 8'h01, wr_enable);
    $display("test poll and write gate done");
  endtask
  // ---------------------------------------------------------------
  // conclusion and main sequence
  // ---------------------------------------------------------------
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    {rst, cmd_valid, res_rd, data_ack, go, non_dma_flag, poll_disable} = 7'h40;
    {count_mode, write_gate_timing, seek_go, seek_outward, sense_int_done, wr_req} = 6'h00;
    {cmd_data, del_mask, precomp_start_track, sectors_per_track} = 32'h0;
    {relative_cylinder, step_interval, nsec} = 16'h0;
    tick(2);
    rst = 1'b0;
    chk("cmd_ready at reset", 8'h01, cmd_ready);
    t_read_plain();
    t_skip(8'h26, 2);
    t_skip(8'h2C, 1);
    t_seek();
    t_poll_write_gate_timing();
    conclude();
  end
endmodule // tb_floppy_read_cmd
